// ==== rtl/flash_suspend_cfg.svh ====
`ifndef FLASH_SUSPEND_CFG_SVH
`define FLASH_SUSPEND_CFG_SVH

// register byte offsets (word aligned)
`define OFS_CMD          8'h00
`define OFS_STATUS       8'h04
`define OFS_PARAM        8'h2c

// suspend parameter word and its fields
`define PARAM_WORD       32'h4518_a3ec
`define PARAM_SUSP_BIT   31
`define PARAM_ERASE_LAT  7'h45
`define PARAM_PROG_LAT   7'h45

// command opcodes
`define OP_ERASE_SUSP    8'h75
`define OP_ERASE_RES     8'h7a
`define OP_PROG_SUSP     8'h85
`define OP_PROG_RES      8'h8a
`define OP_START_ERASE   8'h20
`define OP_START_PROG    8'h02

// status bit positions
`define ST_BUSY          0
`define ST_ERASE_ACT     1
`define ST_PROG_ACT      2
`define ST_ERASE_SUSP    3
`define ST_PROG_SUSP     4
`define ST_REFUSED       5
`define ST_REMAIN_LSB    16

// timing
`define CLK_PERIOD_NS    10
`define SUSP_LAT_NS      48000
`define SUSP_LAT_CYC     (`SUSP_LAT_NS / `CLK_PERIOD_NS)
`define SUSP_SETTLE_CYC  4'h8
`define OP_CYCLES_DEF    50000

`endif

// ==== rtl/flash_suspend_pkg.sv ====
package flash_suspend_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_START_ERASE,
    CMD_START_PROG,
    CMD_SUSP_ERASE,
    CMD_RES_ERASE,
    CMD_SUSP_PROG,
    CMD_RES_PROG
  } cmd_e;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_RUN,
    ENG_SUSP_PEND,
    ENG_SUSP
  } eng_state_e;

  typedef struct packed {
    eng_state_e  state;
    logic        is_erase;
    logic [15:0] remaining;
    logic [3:0]  settle;
    logic        refused;
  } eng_s;

  typedef struct packed {
    logic        dp_valid;
    logic        dp_write;
    logic        dp_hit;
    logic [7:0]  dp_addr;
    logic [31:0] rdata;
    cmd_e        cmd;
    logic        refused;
  } bus_s;

endpackage : flash_suspend_pkg

// ==== rtl/sequencer_if.sv ====
`timescale 1ns/1ps
interface sequencer_if;
  flash_suspend_pkg::cmd_e       cmd;
  flash_suspend_pkg::eng_state_e state;
  logic                          is_erase;
  logic [15:0]                   remaining;
  logic                          busy;
  logic                          refused;

  modport ctl (output cmd, input state, is_erase, remaining, busy, refused);
  modport eng (input cmd, output state, is_erase, remaining, busy, refused);
endinterface : sequencer_if

// ==== rtl/suspend_engine.sv ====
`timescale 1ns/1ps
`include "flash_suspend_cfg.svh"
module suspend_engine #(
  parameter int OP_CYCLES    = `OP_CYCLES_DEF,
  parameter int SUSP_LAT_CYC = `SUSP_LAT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // command and status
  sequencer_if.eng sif
);

  flash_suspend_pkg::eng_s state_reg;
  flash_suspend_pkg::eng_s state_next;
  logic [15:0]             lat_cnt_reg;

  always_comb
  begin
    state_next         = state_reg;
    state_next.refused = 1'b0;
    case (state_reg.state)
      flash_suspend_pkg::ENG_IDLE:
      begin
        if (sif.cmd == flash_suspend_pkg::CMD_START_ERASE || sif.cmd == flash_suspend_pkg::CMD_START_PROG)
        begin
          state_next.state     = flash_suspend_pkg::ENG_RUN;
          state_next.is_erase  = (sif.cmd == flash_suspend_pkg::CMD_START_ERASE);
          state_next.remaining = OP_CYCLES[15:0];
        end
        else if (sif.cmd != flash_suspend_pkg::CMD_NONE)
          state_next.refused = 1'b1;
      end
      flash_suspend_pkg::ENG_RUN:
      begin
        if (state_reg.remaining <= 16'h0001)
        begin
          state_next.state     = flash_suspend_pkg::ENG_IDLE;
          state_next.remaining = 16'h0000;
        end
        else
          state_next.remaining = state_reg.remaining - 16'h0001;
        // suspend of the wrong kind is refused, not remapped
        if (state_reg.remaining > 16'h0001 && sif.cmd == (state_reg.is_erase ? flash_suspend_pkg::CMD_SUSP_ERASE
                                                                                : flash_suspend_pkg::CMD_SUSP_PROG))
        begin
          state_next.state     = flash_suspend_pkg::ENG_SUSP_PEND;
          state_next.remaining = state_reg.remaining;
          state_next.settle    = `SUSP_SETTLE_CYC;
        end
        else if (sif.cmd != flash_suspend_pkg::CMD_NONE)
          state_next.refused = 1'b1;
      end
      flash_suspend_pkg::ENG_SUSP_PEND:
      begin
        // fixed settle keeps latency far under the reported bound
        state_next.settle = state_reg.settle - 4'h1;
        if (state_reg.settle <= 4'h1)
          state_next.state = flash_suspend_pkg::ENG_SUSP;
        if (sif.cmd != flash_suspend_pkg::CMD_NONE)
          state_next.refused = 1'b1;
      end
      flash_suspend_pkg::ENG_SUSP:
      begin
        // progress is frozen, so resume continues where it stopped
        if (sif.cmd == (state_reg.is_erase ? flash_suspend_pkg::CMD_RES_ERASE : flash_suspend_pkg::CMD_RES_PROG))
          state_next.state = flash_suspend_pkg::ENG_RUN;
        else if (sif.cmd != flash_suspend_pkg::CMD_NONE)
          state_next.refused = 1'b1;
      end
      default:
        state_next = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sif.state     = state_reg.state;
  assign sif.is_erase  = state_reg.is_erase;
  assign sif.remaining = state_reg.remaining;
  assign sif.busy      = (state_reg.state == flash_suspend_pkg::ENG_RUN) ||
                         (state_reg.state == flash_suspend_pkg::ENG_SUSP_PEND);
  assign sif.refused   = state_reg.refused;

  // cycles spent waiting for a suspend to take effect
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lat_cnt_reg <= 16'h0000;
    else if (state_reg.state == flash_suspend_pkg::ENG_SUSP_PEND)
      lat_cnt_reg <= lat_cnt_reg + 16'h0001;
    else
      lat_cnt_reg <= 16'h0000;
  end

  chk_erase_susp_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_reg.state == flash_suspend_pkg::ENG_SUSP_PEND && state_reg.is_erase) |-> lat_cnt_reg < SUSP_LAT_CYC)
    else $error("erase suspend latency exceeded");

  chk_prog_susp_latency: assert property (
    @(posedge clk) disable iff (!rst_b)
    (state_reg.state == flash_suspend_pkg::ENG_SUSP_PEND && !state_reg.is_erase) |-> lat_cnt_reg < SUSP_LAT_CYC)
    else $error("program suspend latency exceeded");

  chk_suspend_not_busy: assert property (
    @(posedge clk) disable iff (!rst_b)
    state_reg.state == flash_suspend_pkg::ENG_SUSP |-> !sif.busy)
    else $error("busy shown while suspended");

  chk_resume_keeps_work: assert property (
    @(posedge clk) disable iff (!rst_b)
    ($past(state_reg.state) == flash_suspend_pkg::ENG_SUSP && state_reg.state == flash_suspend_pkg::ENG_RUN)
    |-> state_reg.remaining == $past(state_reg.remaining))
    else $error("resume lost progress");

endmodule : suspend_engine

// ==== rtl/flash_suspend_resume_rules.sv ====
`timescale 1ns/1ps
`include "flash_suspend_cfg.svh"
// How it works
// - parameter word reads constant 4518A3EC
// - top bit zero: suspend/resume supported
// - erase suspends within 48 us
// - program suspends within 48 us
// - erase suspend 75h, resume 7Ah decoded
// - program suspend 85h, resume 8Ah decoded
module flash_suspend_resume_rules #(
  parameter int OP_CYCLES    = `OP_CYCLES_DEF,
  parameter int SUSP_LAT_CYC = `SUSP_LAT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic        hresp,
  output      logic [31:0] hrdata,
  // status
  output      logic        flash_busy
);

  sequencer_if sif ();

  flash_suspend_pkg::bus_s state_reg;
  flash_suspend_pkg::bus_s state_next;

  function automatic flash_suspend_pkg::cmd_e decode_op(input logic [7:0] op);
    case (op)
      `OP_ERASE_SUSP:  decode_op = flash_suspend_pkg::CMD_SUSP_ERASE;
      `OP_ERASE_RES:   decode_op = flash_suspend_pkg::CMD_RES_ERASE;
      `OP_PROG_SUSP:   decode_op = flash_suspend_pkg::CMD_SUSP_PROG;
      `OP_PROG_RES:    decode_op = flash_suspend_pkg::CMD_RES_PROG;
      `OP_START_ERASE: decode_op = flash_suspend_pkg::CMD_START_ERASE;
      `OP_START_PROG:  decode_op = flash_suspend_pkg::CMD_START_PROG;
      default:         decode_op = flash_suspend_pkg::CMD_NONE;
    endcase
  endfunction : decode_op

  function automatic logic [31:0] status_word(input flash_suspend_pkg::eng_state_e st,
                                              input logic erase, input logic busy,
                                              input logic refused, input logic [15:0] remaining);
    logic active;
    logic susp;
    active = (st != flash_suspend_pkg::ENG_IDLE);
    susp   = (st == flash_suspend_pkg::ENG_SUSP);
    status_word                            = 32'h0000_0000;
    status_word[`ST_BUSY]                  = busy;
    status_word[`ST_ERASE_ACT]             = active && erase;
    status_word[`ST_PROG_ACT]              = active && !erase;
    status_word[`ST_ERASE_SUSP]            = susp && erase;
    status_word[`ST_PROG_SUSP]             = susp && !erase;
    status_word[`ST_REFUSED]               = refused;
    status_word[`ST_REMAIN_LSB +: 16]      = remaining;
  endfunction : status_word

  logic addr_take;
  logic addr_hit;
  logic status_rd;

  always_comb
  begin
    state_next     = state_reg;
    state_next.cmd = flash_suspend_pkg::CMD_NONE;
    addr_take      = hsel && hready && htrans[1];
    addr_hit       = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
    status_rd      = addr_take && !hwrite && addr_hit && (haddr[7:0] == `OFS_STATUS);

    // data phase of a write: opcode taken from the low byte
    if (state_reg.dp_valid && state_reg.dp_write && state_reg.dp_hit && state_reg.dp_addr == `OFS_CMD)
      state_next.cmd = decode_op(hwdata[7:0]);

    if (hready)
    begin
      state_next.dp_valid = addr_take;
      state_next.dp_write = hwrite;
      state_next.dp_hit   = addr_hit;
      state_next.dp_addr  = haddr[7:0];
    end

    // read data latched at the address phase so it comes from a flop
    if (addr_take && !hwrite)
    begin
      if (!addr_hit)
        state_next.rdata = 32'h0000_0000;
      else
      begin
        case (haddr[7:0])
          `OFS_PARAM:  state_next.rdata = `PARAM_WORD;
          `OFS_STATUS: state_next.rdata = status_word(sif.state, sif.is_erase, sif.busy,
                                                      state_reg.refused, sif.remaining);
          default:     state_next.rdata = 32'h0000_0000;
        endcase
      end
    end

    // a status read clears the sticky flag; a new refusal wins
    state_next.refused = (state_reg.refused && !status_rd) || sif.refused;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

  assign sif.cmd    = state_reg.cmd;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = state_reg.rdata;
  assign flash_busy = sif.busy;

  suspend_engine #(
    .OP_CYCLES    (OP_CYCLES),
    .SUSP_LAT_CYC (SUSP_LAT_CYC)
  ) u_engine (
    .clk   (clk),
    .rst_b (rst_b),
    .sif   (sif)
  );

  sequence seq_param_read;
    state_reg.dp_valid && !state_reg.dp_write && state_reg.dp_hit && state_reg.dp_addr == `OFS_PARAM;
  endsequence

  sequence seq_cmd_write(logic [7:0] op);
    state_reg.dp_valid && state_reg.dp_write && state_reg.dp_hit &&
    state_reg.dp_addr == `OFS_CMD && hwdata[7:0] == op;
  endsequence

  chk_param_word_value: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_param_read |-> hrdata == 32'h4518_a3ec)
    else $error("parameter word wrong");

  chk_suspend_supported: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_param_read |-> !hrdata[`PARAM_SUSP_BIT])
    else $error("suspend support bit set");

  chk_erase_lat_field: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_param_read |-> hrdata[30:24] == 7'h45)
    else $error("erase latency field wrong");

  chk_prog_lat_field: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_param_read |-> hrdata[19:13] == 7'h45)
    else $error("program latency field wrong");

  chk_erase_susp_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h75) ##0 (sif.state == flash_suspend_pkg::ENG_RUN && sif.is_erase && sif.remaining > 16'h0003)
    |-> ##2 sif.state == flash_suspend_pkg::ENG_SUSP_PEND)
    else $error("erase suspend not decoded");

  chk_erase_res_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h7a) ##0 (sif.state == flash_suspend_pkg::ENG_SUSP && sif.is_erase)
    |-> ##2 sif.state == flash_suspend_pkg::ENG_RUN)
    else $error("erase resume not decoded");

  chk_prog_susp_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h85) ##0 (sif.state == flash_suspend_pkg::ENG_RUN && !sif.is_erase && sif.remaining > 16'h0003)
    |-> ##2 sif.state == flash_suspend_pkg::ENG_SUSP_PEND)
    else $error("program suspend not decoded");

  chk_prog_res_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h8a) ##0 (sif.state == flash_suspend_pkg::ENG_SUSP && !sif.is_erase)
    |-> ##2 sif.state == flash_suspend_pkg::ENG_RUN)
    else $error("program resume not decoded");

  chk_suspended_holds: assert property (
    @(posedge clk) disable iff (!rst_b)
    (sif.state == flash_suspend_pkg::ENG_SUSP && sif.cmd == flash_suspend_pkg::CMD_NONE)
    |=> sif.state == flash_suspend_pkg::ENG_SUSP)
    else $error("suspended operation left without resume");

  sequence seq_status_read;
    state_reg.dp_valid && !state_reg.dp_write && state_reg.dp_hit && state_reg.dp_addr == `OFS_STATUS;
  endsequence

  chk_erase_res_accepted: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h7a) ##0 (sif.state == flash_suspend_pkg::ENG_SUSP && sif.is_erase)
    |-> ##2 !sif.refused)
    else $error("erase resume flagged as refused");

  chk_prog_res_accepted: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h8a) ##0 (sif.state == flash_suspend_pkg::ENG_SUSP && !sif.is_erase)
    |-> ##2 !sif.refused)
    else $error("program resume flagged as refused");

  // only the matching resume may leave a suspend
  chk_nested_start_refused: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_cmd_write(8'h20) ##0 (sif.state == flash_suspend_pkg::ENG_SUSP)
    |-> ##2 sif.refused)
    else $error("nested start not refused");

  chk_refused_set_wins: assert property (
    @(posedge clk) disable iff (!rst_b)
    sif.refused |=> state_reg.refused)
    else $error("refusal lost against status read");

  chk_status_busy_bit: assert property (
    @(posedge clk) disable iff (!rst_b)
    seq_status_read |-> hrdata[`ST_BUSY] == $past(sif.busy))
    else $error("status busy bit wrong");

  chk_pending_shows_busy: assert property (
    @(posedge clk) disable iff (!rst_b)
    sif.state == flash_suspend_pkg::ENG_SUSP_PEND |-> flash_busy)
    else $error("idle shown before suspend took effect");

endmodule : flash_suspend_resume_rules

// ==== verification/ahb_host_model.sv ====
`timescale 1ns/1ps
module ahb_host_model #(
  parameter int GAP_CYC = 12800
) (
  // clock
  input  wire logic        clk,
  // ahb-lite master
  output      logic        hsel,
  output      logic [31:0] haddr,
  output      logic [1:0]  htrans,
  output      logic        hwrite,
  output      logic [2:0]  hsize,
  output      logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  int unsigned cyc;
  int unsigned last_res [2];
  logic        res_seen [2];
  logic        susp;

  initial
  begin
    hsel        = 1'b0;
    haddr       = 32'h0000_0000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0000_0000;
    cyc         = 0;
    res_seen[0] = 1'b0;
    res_seen[1] = 1'b0;
    susp        = 1'b0;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  task automatic wait_rdy(output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++)
    begin
      @(posedge clk);
      ok = (hready === 1'b1);
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    logic ok1;
    hsel   <= 1'b1;
    haddr  <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_rdy(ok1);
    htrans <= 2'b00;
    hwdata <= wr ? wd : ~hwdata;
    wait_rdy(ok);
    rd = hrdata;
    ok = ok & ok1;
    // released data lines never keep the last value
    hwdata <= ~hwdata;
  endtask : xfer

  // rude lets a scenario issue a start command while suspended, which the engine refuses
  task automatic command(input logic [7:0] op, input logic rude, output logic ok);
    logic [31:0] rd;
    logic        k;
    k  = op[7];
    ok = 1'b1;
    if ((op == 8'h75 || op == 8'h85) && res_seen[k])
      while (cyc - last_res[k] < GAP_CYC)
        @(posedge clk);
    // no array access is issued while suspended unless rude is set, so suspended regions stay untouched
    if (susp && !rude && (op == 8'h20 || op == 8'h02))
      return;
    xfer(1'b1, 32'h0000_0000, {24'h00_0000, op}, rd, ok);
    if (op == 8'h75 || op == 8'h85)
      susp = 1'b1;
    if (op == 8'h7a || op == 8'h8a)
    begin
      susp        = 1'b0;
      last_res[k] = cyc;
      res_seen[k] = 1'b1;
    end
  endtask : command
endmodule : ahb_host_model

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        rst_b;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        flash_busy;
  int          bad_count = 0;
  int          num_checks = 0;

  flash_suspend_resume_rules #(.OP_CYCLES(40), .SUSP_LAT_CYC(20)) flash_suspend_resume_rules_inst (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flash_busy(flash_busy));

  ahb_host_model host_inst (
    .clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop;
    if (bad_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    host_inst.xfer(wr, a, wd, rd, ok);
    if (!ok)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask : bus

  task automatic cmd(input logic [7:0] op, input logic rude);
    logic ok;
    host_inst.command(op, rude, ok);
    if (!ok)
    begin
      bad_count++;
      report_and_stop();
    end
    repeat (2) @(posedge clk);
  endtask : cmd

  function automatic logic [4:0] st_exp(input logic er, input logic run, input logic sus);
    return {~er & sus, er & sus, ~er, er, run};
  endfunction : st_exp

  initial
  begin
    repeat (60000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    logic [31:0] d;
    logic [31:0] a;
    logic [15:0] rem;
    logic [7:0]  op;
    logic        er;
    int          n;
    d     = $urandom(32'h3e8b);
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    check("reset hrdata", hrdata, 32'h0000_0000);
    check("reset ready", {hreadyout, hresp, flash_busy}, 32'h0000_0004);
    rst_b <= 1'b1;
    @(posedge clk);
    bus(1'b0, 32'h0000_002c, 32'h0000_0000, d);
    check("param word", d, 32'h4518_a3ec);
    check("suspend supported", d[31], 32'h0000_0000);
    check("erase latency", d[30:24], 32'h0000_0045);
    check("program latency", d[19:13], 32'h0000_0045);
    for (n = 0; n < 8; n++)
    begin
      a = $urandom_range(3, 63) * 4;
      if (a == 32'h0000_002c)
        a = 32'h0000_0030;
      bus(1'b1, a, $urandom(), d);
      bus(1'b0, a, 32'h0000_0000, d);
      check("unmapped read", d, 32'h0000_0000);
      bus(1'b1, 32'h0000_002c, $urandom(), d);
      bus(1'b0, 32'h0000_002c, 32'h0000_0000, d);
      check("param read only", d, 32'h4518_a3ec);
      op = 8'h20;
      case ($urandom_range(0, 5))
        0: op = 8'h02;
        1: op = 8'h75;
        2: op = 8'h7a;
        3: op = 8'h85;
        4: op = 8'h8a;
        default: op = 8'h20;
      endcase
      cmd(op ^ 8'h01, 1'b0);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("unknown opcode", d, 32'h0000_0000);
    end
    for (n = 0; n < 2; n++)
    begin
      er = (n == 0);
      cmd(er ? 8'h20 : 8'h02, 1'b0);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("running", d[4:0], st_exp(er, 1'b1, 1'b0));
      check("busy pin", flash_busy, 32'h0000_0001);
      cmd(er ? 8'h75 : 8'h85, 1'b0);
      for (int t = 0; t < 30 && d[0] !== 1'b0; t++)
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("suspended", d[4:0], st_exp(er, 1'b0, 1'b1));
      check("idle pin", flash_busy, 32'h0000_0000);
      rem = d[31:16];
      cmd(er ? 8'h20 : 8'h02, 1'b1);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("nested refused", d[5], 32'h0000_0001);
      check("work frozen", d[31:16], rem);
      bus(1'b0, 32'h0000_002c, 32'h0000_0000, d);
      check("param while suspended", d, 32'h4518_a3ec);
      cmd(er ? 8'h7a : 8'h8a, 1'b0);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("resumed", d[4:0], st_exp(er, 1'b1, 1'b0));
      check("work continues", d[31:16] < rem && d[31:16] > rem - 16'h0008, 32'h0000_0001);
      for (int t = 0; t < 40 && d[0] !== 1'b0; t++)
        bus(1'b0, 32'h0000_0004, 32'h0000_0000, d);
      check("completed", d[4:0], 32'h0000_0000);
    end
    report_and_stop();
  end
endmodule : tb_top
